//--- rtl/rsd_map.vh
`ifndef RSD_MAP_VH
`define RSD_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define RSD_ADDR_READOUT     8'h2d
`define RSD_ADDR_CMDSTAT     8'h2e
`define RSD_ADDR_REVISION    8'h33

// ****************************************
// Readout page codes
// ****************************************
`define RSD_PAGE_CONV        2'h0
`define RSD_PAGE_OSC         2'h1

// ****************************************
// Direct command codes
// ****************************************
`define RSD_CMD_HOP_MAIN     8'h84
`define RSD_CMD_HOP_AUX      8'h85
`define RSD_CMD_CONV         8'h87
`define RSD_CMD_FCAL         8'h88
`define RSD_CMD_SUPP_AUTO    8'ha2
`define RSD_CMD_SUPP_MAN     8'ha3
`define RSD_CMD_VCO_AUTO     8'ha4
`define RSD_CMD_VCO_MAN      8'ha5
`define RSD_CMD_GAIN_ON      8'ha6
`define RSD_CMD_GAIN_OFF     8'ha7
`define RSD_CMD_STR_STORE    8'ha8
`define RSD_CMD_STR_CLEAR    8'ha9

// ****************************************
// Command status field positions
// ****************************************
`define RSD_BIT_STRENGTH     7
`define RSD_BIT_OSCRANGE     6
`define RSD_BIT_SUPPLY       5
`define RSD_BIT_FCAL         4
`define RSD_BIT_CONV         3
`define RSD_BIT_ANTICOLL     2
`define RSD_BIT_GAIN         1
`define RSD_BIT_AUXSYN       0

// ****************************************
// Reset values and timing
// ****************************************
`define RSD_RST_BYTE         8'h00
`define RSD_CONV_TIME_NS     20000
`define RSD_CLK_PERIOD_NS    20

`endif

//--- rtl/rsd_status_regs.v
// Notes on behaviour
// RULE1: Page 00 shows converter result, 01 oscillator/supply.
// RULE2: Four-bit input select picks converter input.
// RULE3: Inputs: two mixer DC levels, external pin.
// RULE4: Conversion starts on trigger command; 20 us.
// RULE5: Page-1 bit 7: 0 crystal, 1 reference module.
// RULE6: Page-1 bits 2..0 give supply code.
// RULE7: Page-1 bits 6..3 read zero.
// RULE8: Bit 7 set on strength store/clear done.
// RULE9: Bit 6 set on oscillator range done.
// RULE10: Bit 5 set on supply setting done.
// RULE11: Bit 4 set on filter calibration done.
// RULE12: Bit 3 set on conversion done.
// RULE13: Bit 2 shows anti-collision support enabled.
// RULE14: Bit 1 shows gain limiting active.
// RULE15: Bit 0 shows auxiliary synthesizer selected.
// RULE16: Fixed read-only version register.
// RULE17: Flags always set; enabled ones raise interrupt. Code: one flag (bit 3) for all done events, under a single enable.
// RULE18: Host writes to these registers ignored.
`timescale 1ns/1ps
`include "rsd_map.vh"

module rsd_status_regs #(
  parameter [7:0] VERSION_CODE = 8'h5a,  // Arbitrary value
  parameter       CONV_CYCLES  = 1000,
  parameter       OP_CYCLES    = 4
)(
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       hostWrEn,
  input  wire       hostRdEn,
  input  wire [7:0] hostAddr,
  input  wire [7:0] hostWrData,
  output reg  [7:0] hostRdData,
  output reg        hostRdValid,
  input  wire       cmdValid,
  input  wire [7:0] cmdCode,
  input  wire [1:0] readout_page_sel,
  input  wire [3:0] inputSel,
  input  wire [7:0] mixerIDc,
  input  wire [7:0] mixerQDc,
  input  wire [7:0] extPinDc,
  input  wire       osc_input_pin,
  input  wire [2:0] supply_setting_code,
  input  wire       anticollision_enabled,
  input  wire       cmdIrqEnable,
  input  wire       cmdIrqClear,
  output reg  [7:0] cmdIrqFlags,
  output reg        irqOut,
  output reg        strength_store_finished
);

  // ****************************************
  // Converter timing
  // ****************************************
  // Ceiling of the conversion time in clock cycles
  localparam [15:0] CONV_MIN = (`RSD_CONV_TIME_NS + `RSD_CLK_PERIOD_NS - 1) / `RSD_CLK_PERIOD_NS;
  localparam [15:0] CONV_LOAD = CONV_CYCLES;
  localparam [3:0]  OP_LOAD   = OP_CYCLES;

  // One-hot converter states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg [1:0]  convState_r;
  reg [1:0]  convState_nxt;
  reg [15:0] convCnt_r;
  reg [7:0]  convResult_r;
  reg [7:0]  convSample_r;
  reg [7:0]  cmdStatus_r;
  reg [3:0]  opCnt_r;
  reg [2:0]  opKind_r;
  reg        oscMode_r;
  reg [2:0]  supply_r;
  reg        convDone;
  reg        opDone;

  // Converter input multiplexer
  function [7:0] rsd_pick;
    input [3:0] sel;
    input [7:0] mi;
    input [7:0] mq;
    input [7:0] ext;
    begin
      case (sel)
        4'h0:    rsd_pick = mi;   // RULE3
        4'h1:    rsd_pick = mq;
        4'h2:    rsd_pick = ext;
        default: rsd_pick = 8'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // Next state of the converter
  always @*
  begin
    convState_nxt = convState_r;
    convDone      = 1'b0;
    case (convState_r)
      ST_IDLE:
      begin
        if (cmdValid && cmdCode == `RSD_CMD_CONV)  // RULE4
          convState_nxt = ST_BUSY;
      end
      ST_BUSY:
      begin
        if (convCnt_r == 16'h0001)
        begin
          convState_nxt = ST_IDLE;
          convDone      = 1'b1;                    // RULE12
        end
      end
      default: convState_nxt = ST_IDLE;
    endcase
  end

  // Converter registers; sample taken at start, result published at end
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      convState_r  <= ST_IDLE;
      convCnt_r    <= 16'h0000;
      convResult_r <= `RSD_RST_BYTE;
      convSample_r <= `RSD_RST_BYTE;
    end
    else
    begin
      convState_r <= convState_nxt;
      if (convState_r == ST_IDLE && convState_nxt == ST_BUSY)
      begin
        convCnt_r    <= (CONV_LOAD < CONV_MIN) ? CONV_MIN : CONV_LOAD;
        convSample_r <= rsd_pick(inputSel, mixerIDc, mixerQDc, extPinDc);  // RULE2
      end
      else if (convCnt_r != 16'h0000)
        convCnt_r <= convCnt_r - 16'h0001;
      if (convDone)
        convResult_r <= convSample_r;  // RULE2
    end
  end

  // ****************************************
  // Other direct commands
  // ****************************************
  // Short operations finish after a fixed delay
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      opCnt_r  <= 4'h0;
      opKind_r <= 3'h0;
      opDone   <= 1'b0;
    end
    else
    begin
      opDone <= 1'b0;
      if (cmdValid && opCnt_r == 4'h0)
      begin
        case (cmdCode)
          `RSD_CMD_STR_STORE, `RSD_CMD_STR_CLEAR: begin opKind_r <= 3'h7; opCnt_r <= OP_LOAD; end
          `RSD_CMD_VCO_AUTO,  `RSD_CMD_VCO_MAN:   begin opKind_r <= 3'h6; opCnt_r <= OP_LOAD; end
          `RSD_CMD_SUPP_AUTO, `RSD_CMD_SUPP_MAN:  begin opKind_r <= 3'h5; opCnt_r <= OP_LOAD; end
          `RSD_CMD_FCAL:                          begin opKind_r <= 3'h4; opCnt_r <= OP_LOAD; end
          default: opCnt_r <= 4'h0;
        endcase
      end
      else if (opCnt_r != 4'h0)
      begin
        opCnt_r <= opCnt_r - 4'h1;
        opDone  <= (opCnt_r == 4'h1);
      end
    end
  end

  // ****************************************
  // Command status and interrupt flags
  // ****************************************
  // Done bits are sticky and cleared only by reset
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmdStatus_r <= `RSD_RST_BYTE;
      cmdIrqFlags <= `RSD_RST_BYTE;
      irqOut      <= 1'b0;
      oscMode_r   <= 1'b0;
      supply_r    <= 3'h0;
      strength_store_finished <= 1'b0;
    end
    else
    begin
      oscMode_r <= osc_input_pin;           // RULE5
      supply_r  <= supply_setting_code;     // RULE6
      if (cmdValid && cmdCode == `RSD_CMD_GAIN_ON)
        cmdStatus_r[`RSD_BIT_GAIN] <= 1'b1;     // RULE14
      else if (cmdValid && cmdCode == `RSD_CMD_GAIN_OFF)
        cmdStatus_r[`RSD_BIT_GAIN] <= 1'b0;     // RULE14
      if (cmdValid && cmdCode == `RSD_CMD_HOP_AUX)
        cmdStatus_r[`RSD_BIT_AUXSYN] <= 1'b1;   // RULE15
      else if (cmdValid && cmdCode == `RSD_CMD_HOP_MAIN)
        cmdStatus_r[`RSD_BIT_AUXSYN] <= 1'b0;   // RULE15
      cmdStatus_r[`RSD_BIT_ANTICOLL] <= anticollision_enabled;  // RULE13
      if (opDone)
        cmdStatus_r[opKind_r] <= 1'b1;          // RULE8 RULE9 RULE10 RULE11
      if (convDone)
        cmdStatus_r[`RSD_BIT_CONV] <= 1'b1;     // RULE12
      strength_store_finished <= cmdStatus_r[`RSD_BIT_STRENGTH];
      // Interrupt flag always set, set wins over clear
      if (opDone || convDone)
        cmdIrqFlags[`RSD_BIT_CONV] <= 1'b1;     // RULE17
      else if (cmdIrqClear)
        cmdIrqFlags[`RSD_BIT_CONV] <= 1'b0;
      irqOut <= cmdIrqEnable & (cmdIrqFlags[`RSD_BIT_CONV] | opDone | convDone);  // RULE17
    end
  end

  // ****************************************
  // Host read port
  // ****************************************
  // Writes never reach the display registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      hostRdData  <= `RSD_RST_BYTE;
      hostRdValid <= 1'b0;
    end
    else
    begin
      hostRdValid <= hostRdEn & ~hostWrEn;      // RULE18
      if (hostRdEn && !hostWrEn)
      begin
        case (hostAddr)
          `RSD_ADDR_READOUT:
            if (readout_page_sel == `RSD_PAGE_OSC)
              hostRdData <= {oscMode_r, 4'h0, supply_r};  // RULE1 RULE5 RULE7 RULE6
            else
              hostRdData <= convResult_r;                 // RULE1
          `RSD_ADDR_CMDSTAT:  hostRdData <= cmdStatus_r;
          `RSD_ADDR_REVISION: hostRdData <= VERSION_CODE; // RULE16
          default:            hostRdData <= 8'h00;
        endcase
      end
    end
  end

endmodule // rsd_status_regs

//--- verif/rsd_status_regs_monitor.sv
`timescale 1ns/1ps
// ****************
// Status bank checks
// ****************
module rsd_status_regs_monitor #(parameter [7:0] VERSION_CODE = 8'h5a)(
  input logic       clk_sys,
  input logic       rst,
  input logic       hostWrEn,
  input logic       hostRdEn,
  input logic [7:0] hostAddr,
  input logic [7:0] hostRdData,
  input logic       hostRdValid,
  input logic [1:0] readout_page_sel,
  input logic       osc_input_pin,
  input logic [2:0] supply_setting_code,
  input logic       anticollision_enabled,
  input logic       cmdIrqEnable,
  input logic [7:0] cmdIrqFlags,
  input logic       irqOut,
  input logic       strength_store_finished
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Read taken on this edge
  wire rdTake = hostRdEn & !hostWrEn;
  property p_version; rdTake && hostAddr == 8'h33 |=> hostRdData == VERSION_CODE; endproperty
  a_version: assert property (p_version) else $error("version byte wrong");
  property p_page1;
    rdTake && hostAddr == 8'h2d && readout_page_sel == 2'h1
      |=> hostRdData == {$past(osc_input_pin, 2), 4'h0, $past(supply_setting_code, 2)};
  endproperty
  a_page1: assert property (p_page1) else $error("oscillator page wrong");
  property p_anticoll; rdTake && hostAddr == 8'h2e |=> hostRdData[2] == $past(anticollision_enabled, 2); endproperty
  a_anticoll: assert property (p_anticoll) else $error("anticollision bit wrong");
  property p_wrIgn; !rdTake |=> !hostRdValid && $stable(hostRdData); endproperty
  a_wrIgn: assert property (p_wrIgn) else $error("read data moved without read");
  property p_irqOff; !cmdIrqEnable |=> !irqOut; endproperty
  a_irqOff: assert property (p_irqOff) else $error("interrupt while disabled");
  property p_irqOn; cmdIrqFlags[3] && cmdIrqEnable |=> irqOut; endproperty
  a_irqOn: assert property (p_irqOn) else $error("interrupt missing");
  property p_strSticky; strength_store_finished |=> strength_store_finished; endproperty
  a_strSticky: assert property (p_strSticky) else $error("strength done bit lost");
  property p_strFlag; $rose(strength_store_finished) |-> ##[0:1] cmdIrqFlags[3]; endproperty
  a_strFlag: assert property (p_strFlag) else $error("strength done raised no flag");
  cover property (rdTake && hostAddr == 8'h2d);
  cover property ($rose(irqOut));
  cover property ($rose(strength_store_finished));
endmodule // rsd_status_regs_monitor
bind rsd_status_regs rsd_status_regs_monitor #(.VERSION_CODE(VERSION_CODE)) mon (.clk_sys, .rst, .hostWrEn,
  .hostRdEn, .hostAddr, .hostRdData, .hostRdValid, .readout_page_sel, .osc_input_pin, .supply_setting_code,
  .anticollision_enabled, .cmdIrqEnable, .cmdIrqFlags, .irqOut, .strength_store_finished);

//--- verif/rsd_host_model.sv
`timescale 1ns/1ps
// ****************
// Host controller model
// ****************
module rsd_host_model #(parameter CONV_WAIT = 1000)(
  input  logic       clk_sys,
  input  logic [7:0] hostRdData,
  input  logic       hostRdValid,
  output logic       hostWrEn = 0,
  output logic       hostRdEn = 0,
  output logic [7:0] hostAddr = 8'h00,
  output logic [7:0] hostWrData = 8'h00,
  output logic       cmdValid = 0,
  output logic [7:0] cmdCode = 8'h00
);
  // Register read, address scrambled once released
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys) {hostRdEn, hostAddr} = {1'b1, a};
    @(negedge clk_sys) {hostRdEn, hostAddr} = {1'b0, ~a};
    if (!hostRdValid) @(negedge clk_sys);
    d = hostRdData;
  endtask
  // Register write attempt
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys) {hostWrEn, hostAddr, hostWrData} = {1'b1, a, v};
    @(negedge clk_sys) {hostWrEn, hostAddr, hostWrData} = {1'b0, ~a, ~v};
  endtask
  // Direct command pulse
  task cmd(input logic [7:0] c);
    @(negedge clk_sys) {cmdValid, cmdCode} = {1'b1, c};
    @(negedge clk_sys) {cmdValid, cmdCode} = {1'b0, ~c};
  endtask
  // Readout trusted only after the conversion time
  task conv_wait;
    repeat (CONV_WAIT + 2) @(negedge clk_sys);
  endtask
endmodule // rsd_host_model

//--- verif/reader_status_display_regs_test.sv
`timescale 1ns/1ps
// ****************
// Status bank bench
// ****************
module reader_status_display_regs_test;
  logic clk_sys = 0, rst = 1, hostWrEn, hostRdEn, hostRdValid, cmdValid, osc_input_pin = 0;
  logic anticollision_enabled = 0, cmdIrqEnable = 0, cmdIrqClear = 0, irqOut, strength_store_finished;
  logic [7:0] hostAddr, hostWrData, hostRdData, cmdCode, cmdIrqFlags, d;
  logic [7:0] mixerIDc = 8'ha1, mixerQDc = 8'hb2, extPinDc = 8'hc3;
  logic [1:0] readout_page_sel = 2'h0;
  logic [3:0] inputSel = 4'h0;
  logic [2:0] supply_setting_code = 3'h0;
  logic [7:0] codes [11] = '{8'ha8, 8'ha9, 8'ha4, 8'ha5, 8'ha2, 8'ha3, 8'h88, 8'ha6, 8'ha7, 8'h85, 8'h84};
  logic [7:0] stat [11] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h10, 8'h12, 8'h10, 8'h11, 8'h10};
  int errors = 0, total_checks = 0;
  rsd_status_regs #(.VERSION_CODE(8'h3c), .CONV_CYCLES(1000), .OP_CYCLES(4)) dut (.clk_sys, .rst, .hostWrEn,
    .hostRdEn, .hostAddr, .hostWrData, .hostRdData, .hostRdValid, .cmdValid, .cmdCode, .readout_page_sel,
    .inputSel, .mixerIDc, .mixerQDc, .extPinDc, .osc_input_pin, .supply_setting_code, .anticollision_enabled,
    .cmdIrqEnable, .cmdIrqClear, .cmdIrqFlags, .irqOut, .strength_store_finished);
  rsd_host_model #(.CONV_WAIT(1000)) host (.clk_sys, .hostRdData, .hostRdValid, .hostWrEn, .hostRdEn,
    .hostAddr, .hostWrData, .cmdValid, .cmdCode);
  // Clock
  always #10 clk_sys = ~clk_sys;
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("[ERR] %s exp %h got %h", n, exp, seen);
  endtask
  task complete_run;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task do_reset;
    @(negedge clk_sys) rst = 1;
    repeat (8) @(negedge clk_sys);
    rst = 0;
  endtask
  // Version, anticollision bit, writes ignored
  task t_regs;
    anticollision_enabled = 1;
    host.wr(8'h33, 8'hff);
    host.wr(8'h2e, 8'hff);
    host.rd(8'h33, d); check("revision", d, 8'h3c);
    host.rd(8'h2e, d); check("cmdstat", d, 8'h04);
    anticollision_enabled = 0;
  endtask
  // Oscillator and supply page over all codes
  task t_pages;
    readout_page_sel = 2'h1;
    for (int i = 0; i < 8; i++)
    begin
      osc_input_pin = i[0];
      supply_setting_code = i[2:0];
      host.rd(8'h2d, d); check("page1", d, {i[0], 4'h0, i[2:0]});
    end
  endtask
  // Every direct command except conversion, its status bit and interrupt
  task t_cmds;
    for (int k = 0; k < 11; k++)
    begin
      if (k < 7) do_reset;
      cmdIrqEnable = k[0];
      host.cmd(codes[k]);
      repeat (7) @(negedge clk_sys);
      host.rd(8'h2e, d); check("cmdstat", d, stat[k]);
      if (k < 7) check("irq", {6'h0, cmdIrqFlags[3], irqOut}, {6'h0, 1'b1, k[0]});
      if (k < 7) check("strdone", {7'h0, strength_store_finished}, {7'h0, k < 2});
      cmdIrqClear = 1;
      @(negedge clk_sys) cmdIrqClear = 0;
      repeat (2) @(negedge clk_sys);
      check("irqclr", {6'h0, cmdIrqFlags[3], irqOut}, 8'h00);
    end
  endtask
  // Conversion of each selectable input
  task t_conv;
    readout_page_sel = 2'h0;
    do_reset;
    for (int s = 0; s < 3; s++)
    begin
      inputSel = s[3:0];
      host.cmd(8'h87);
      if (s == 0) repeat (985) @(negedge clk_sys);
      if (s == 0) host.rd(8'h2e, d);
      if (s == 0) check("early", d & 8'h08, 8'h00);
      host.conv_wait;
      host.rd(8'h2e, d); check("convdone", d & 8'h08, 8'h08);
      host.rd(8'h2d, d); check("adc", d, s == 0 ? 8'ha1 : s == 1 ? 8'hb2 : 8'hc3);
    end
  endtask
  initial
  begin
    do_reset;
    t_regs;
    t_pages;
    t_cmds;
    t_conv;
    complete_run;
  end
  // Watchdog
  initial
  begin
    #400000;
    errors++;
    complete_run;
  end
endmodule // reader_status_display_regs_test
